/* File: rtl/vat_translator.sv */
// address translator unit: two buffers, lookup, protection, fill counter
`timescale 1ns/1ps
module vat_translator (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic i_req,
  input wire logic [23:0] i_vaddr,
  input wire logic i_op_read,
  input wire logic i_op_write,
  input wire logic i_op_fetch,
  output logic o_ready,
  output logic o_done,
  output logic o_hit_a,
  output logic o_hit_b,
  output logic o_miss,
  output logic o_prot_err,
  output logic o_go,
  output logic o_micro_int,
  output logic [23:0] o_phys_addr
);

  typedef struct packed {
    vat_pkg::vat_stage_t stage;
    logic [31:0] ctrl;
    logic [23:0] entry;
    logic [23:0] vaddr;
    logic op_rd;
    logic op_wr;
    logic op_fx;
    logic alt;
    logic valid_a;
    logic valid_b;
    logic miss_flag;
    logic prot_flag;
    logic [26:0] rdback;
    logic [31:0] rdata;
    logic done;
    logic hit_a;
    logic hit_b;
    logic miss;
    logic prot;
    logic go;
    logic irq;
    logic [23:0] phys;
  } vat_state_t;

  vat_state_t st_reg;
  vat_state_t st_next;

  logic cnt_run;
  logic ent_wr;
  logic wr_any;
  logic [23:0] wr_data;
  logic [26:0] wr_word;
  logic [1:0] wr_sel;
  logic we_a;
  logic we_b;
  logic [8:0] waddr;
  logic [8:0] raddr;
  logic [26:0] rd_a;
  logic [26:0] rd_b;

  // counter runs while bit 10 is clear and no carry has reached bit 21
  assign cnt_run = !st_reg.ctrl[vat_pkg::CTL_STOP]
    && !st_reg.ctrl[vat_pkg::CTL_CNT_DONE];
  assign ent_wr = i_reg_wr && (i_reg_addr == vat_pkg::ADDR_ENTRY);
  assign wr_any = ent_wr || cnt_run;
  // isolation forces an all-zero word, invalidating the entry
  assign wr_data = st_reg.ctrl[vat_pkg::CTL_ISOLATE] ? 24'h00_0000
    : (ent_wr ? i_reg_wdata[23:0] : st_reg.entry);
  assign wr_word = {vat_pkg::vat_parity(wr_data), wr_data};

  // write select: bit 28 set follows bit 27, else the invalid buffer or alternate
  always_comb begin
    if (st_reg.ctrl[vat_pkg::CTL_ADDR_SRC]) begin
      wr_sel = st_reg.ctrl[vat_pkg::CTL_BUF_SEL] ? 2'h2 : 2'h1;
    end else if (!st_reg.valid_a) begin
      wr_sel = 2'h1;
    end else if (!st_reg.valid_b) begin
      wr_sel = 2'h2;
    end else begin
      wr_sel = st_reg.alt ? 2'h2 : 2'h1;
    end
  end

  assign we_a = wr_any && wr_sel[0];
  assign we_b = wr_any && wr_sel[1];
  // address source: latched virtual address or the counter within its task area
  assign waddr = st_reg.ctrl[vat_pkg::CTL_ADDR_SRC]
    ? vat_pkg::vat_index(st_reg.ctrl, st_reg.vaddr)
    : {st_reg.ctrl[9:7], st_reg.ctrl[5:0]};
  assign raddr = vat_pkg::vat_index(st_reg.ctrl, i_vaddr);

  vat_mem #(
    .WIDTH(vat_pkg::MEM_W),
    .DEPTH(vat_pkg::BUF_DEPTH),
    .AW(vat_pkg::IDX_W)
  ) u_buf_a (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_we(we_a),
    .i_waddr(waddr),
    .i_wdata(wr_word),
    .i_raddr(raddr),
    .o_rdata(rd_a)
  );

  vat_mem #(
    .WIDTH(vat_pkg::MEM_W),
    .DEPTH(vat_pkg::BUF_DEPTH),
    .AW(vat_pkg::IDX_W)
  ) u_buf_b (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_we(we_b),
    .i_waddr(waddr),
    .i_wdata(wr_word),
    .i_raddr(raddr),
    .o_rdata(rd_b)
  );

  always_comb begin
    logic bypass;
    logic ha;
    logic hb;
    logic [23:0] ent;
    logic viol;
    logic [6:0] inc;
    bypass = !st_reg.ctrl[vat_pkg::CTL_XLATE_ON];
    ha = 1'b0;
    hb = 1'b0;
    ent = 24'h00_0000;
    viol = 1'b0;
    inc = 7'h00;
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.irq = 1'b0;

    // control register write; counter fields load only while bit 21 is one
    if (i_reg_wr && (i_reg_addr == vat_pkg::ADDR_CTRL)) begin
      st_next.ctrl[31:22] = i_reg_wdata[31:22];
      st_next.ctrl[20:11] = i_reg_wdata[20:11];
      if (st_reg.ctrl[vat_pkg::CTL_CNT_DONE]) begin
        st_next.ctrl[21] = i_reg_wdata[21];
        st_next.ctrl[10:0] = i_reg_wdata[10:0];
      end
    end
    if (ent_wr) begin
      st_next.entry = i_reg_wdata[23:0];
    end

    // counter step: bits 7..9 untouched, carry out of the line sets bit 21
    if (cnt_run) begin
      inc = {1'b0, st_reg.ctrl[5:0]} + 7'h01;
      st_next.ctrl[5:0] = inc[5:0];
      st_next.ctrl[vat_pkg::CTL_CNT_DONE] = inc[6];
    end
    if (wr_any && st_reg.valid_a && st_reg.valid_b && !st_reg.ctrl[vat_pkg::CTL_ADDR_SRC]) begin
      st_next.alt = !st_reg.alt;
    end

    // status flags: write one to clear, a new event wins
    if (i_reg_wr && (i_reg_addr == vat_pkg::ADDR_STATUS)) begin
      if (i_reg_wdata[vat_pkg::STAT_MISS]) begin
        st_next.miss_flag = 1'b0;
      end
      if (i_reg_wdata[vat_pkg::STAT_PROT]) begin
        st_next.prot_flag = 1'b0;
      end
    end

    case (st_reg.stage)
      vat_pkg::VAT_IDLE: begin
        if (i_req) begin
          st_next.vaddr = i_vaddr;
          st_next.op_rd = i_op_read;
          st_next.op_wr = i_op_write;
          st_next.op_fx = i_op_fetch;
          st_next.stage = vat_pkg::VAT_LOOK;
        end
      end
      vat_pkg::VAT_LOOK: begin
        ha = bypass || vat_pkg::vat_match(rd_a, st_reg.vaddr);
        hb = !bypass && vat_pkg::vat_match(rd_b, st_reg.vaddr);
        ent = ha ? rd_a[23:0] : rd_b[23:0];
        viol = !bypass && (ha || hb) && (
          (st_reg.op_rd && !ent[vat_pkg::ENT_PERM_RD]) ||
          (st_reg.op_wr && !ent[vat_pkg::ENT_PERM_WR]) ||
          (st_reg.op_fx && !ent[vat_pkg::ENT_PERM_EX]));
        st_next.valid_a = rd_a[vat_pkg::ENT_VALID];
        st_next.valid_b = rd_b[vat_pkg::ENT_VALID];
        st_next.rdback = st_reg.ctrl[vat_pkg::CTL_BUF_SEL] ? rd_b : rd_a;
        st_next.hit_a = ha;
        st_next.hit_b = hb && !ha;
        st_next.miss = !(ha || hb);
        st_next.prot = viol;
        st_next.go = (ha || hb) && !viol;
        st_next.irq = !(ha || hb) || viol;
        st_next.done = 1'b1;
        if (bypass) begin
          st_next.phys = {st_reg.vaddr[23:11], st_reg.vaddr[10:0]};
        end else begin
          st_next.phys = {ent[23:11], st_reg.vaddr[10:0]};
        end
        if (!(ha || hb)) begin
          st_next.miss_flag = 1'b1;
        end
        if (viol) begin
          st_next.prot_flag = 1'b1;
          st_next.ctrl[vat_pkg::CTL_ACCESS_EN] = 1'b0;
        end
        st_next.stage = vat_pkg::VAT_IDLE;
      end
      default: begin
        st_next.stage = vat_pkg::VAT_IDLE;
      end
    endcase

    // register read port, data one cycle later
    st_next.rdata = 32'h0000_0000;
    if (i_reg_rd) begin
      if (i_reg_addr == vat_pkg::ADDR_CTRL) begin
        st_next.rdata = st_reg.ctrl;
      end else if (i_reg_addr == vat_pkg::ADDR_ENTRY) begin
        st_next.rdata = {8'h00, st_reg.entry};
      end else if (i_reg_addr == vat_pkg::ADDR_STATUS) begin
        st_next.rdata = {28'h000_0000, st_reg.alt, st_reg.stage == vat_pkg::VAT_LOOK,
          st_reg.prot_flag, st_reg.miss_flag};
      end else if (i_reg_addr == vat_pkg::ADDR_RDBACK) begin
        st_next.rdata = {5'h00, st_reg.rdback};
      end else begin
        st_next.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
      st_reg.stage <= vat_pkg::VAT_IDLE;
      st_reg.ctrl <= vat_pkg::CTRL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_ready = (st_reg.stage == vat_pkg::VAT_IDLE);
  assign o_reg_rdata = st_reg.rdata;
  assign o_done = st_reg.done;
  assign o_hit_a = st_reg.hit_a;
  assign o_hit_b = st_reg.hit_b;
  assign o_miss = st_reg.miss;
  assign o_prot_err = st_reg.prot;
  assign o_go = st_reg.go;
  assign o_micro_int = st_reg.irq;
  assign o_phys_addr = st_reg.phys;

  // checks
  sequence s_accept;
    o_ready && i_req;
  endsequence

  sequence s_answer;
    s_accept ##2 o_done;
  endsequence

  property p_answer_time;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    s_accept |=> (!o_ready && !o_done) ##1 (o_done && o_ready);
  endproperty
  a_answer_time: assert property (p_answer_time) else $error("lookup answer late");

  property p_miss_blocks;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_done && o_miss |-> !o_go && o_micro_int && !o_hit_a && !o_hit_b;
  endproperty
  a_miss_blocks: assert property (p_miss_blocks) else $error("miss did not block go");

  property p_prot_clears;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_done && o_prot_err |-> !o_go && o_micro_int && !st_reg.ctrl[vat_pkg::CTL_ACCESS_EN];
  endproperty
  a_prot_clears: assert property (p_prot_clears) else $error("violation not handled");

  property p_phys_low;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    s_answer |-> o_phys_addr[10:0] == $past(i_vaddr[10:0], 2);
  endproperty
  a_phys_low: assert property (p_phys_low) else $error("offset bits not passed");

  property p_bypass;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    s_accept ##0 !st_reg.ctrl[vat_pkg::CTL_XLATE_ON] ##1 !st_reg.ctrl[vat_pkg::CTL_XLATE_ON]
      |=> o_hit_a && o_go == !o_prot_err && o_phys_addr == $past(st_reg.vaddr);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass address wrong");

  property p_isolate;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (we_a || we_b) && st_reg.ctrl[vat_pkg::CTL_ISOLATE] |-> wr_word == 27'h000_0000;
  endproperty
  a_isolate: assert property (p_isolate) else $error("isolated write not zero");

  property p_cnt_stop;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    st_reg.ctrl[vat_pkg::CTL_CNT_DONE] && !i_reg_wr |=> $stable(st_reg.ctrl[9:0]);
  endproperty
  a_cnt_stop: assert property (p_cnt_stop) else $error("counter moved while stopped");

  property p_task_fixed;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    cnt_run && !i_reg_wr |=> st_reg.ctrl[9:6] == $past(st_reg.ctrl[9:6])
      && (st_reg.ctrl[5:0] == $past(st_reg.ctrl[5:0]) + 6'h01);
  endproperty
  a_task_fixed: assert property (p_task_fixed) else $error("counter step wrong");

  property p_select;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_any && st_reg.ctrl[vat_pkg::CTL_ADDR_SRC] |-> we_b == st_reg.ctrl[vat_pkg::CTL_BUF_SEL]
      && we_a != we_b;
  endproperty
  a_select: assert property (p_select) else $error("buffer select wrong");

endmodule

/* File: inc/vat_pkg.sv */
// constants, types and helpers shared by the virtual address translation buffer
// What this block does
// - translate a virtual address from the latch into a physical memory or cache address
// - two translation buffers, a and b, 512 words of 27 bits, plus a 10-bit counter
// - each buffer splits into eight task areas of 64 consecutive entries
// - entry bits 6..0 hold the tag, compared with address bits 23..20 and 16..14
// - three protection bits; bits 10..8 grant read, write and execute
// - entry bit 7 is the valid flag; invalid entries never translate
// - entry bits 23..11 hold the 13-bit relocation value sent onward
// - three parity bits, one per byte of the 24 entry data bits
// - in bypass, address bits 23..11 go out as buffer a relocation
// - control bit 27 picks buffer a or b for readback, and for writes while bit 28 is set
// - control bit 28 picks latch address or counter address for the buffers
// - control bit 29 cuts off the destination bus and writes all zeros
// - counter sits in control bits 0..9; clearing bit 10 starts it
// - bits 7..9 stay fixed while counting and pick the task area
// - counter stops on carry into bit 21; while bit 21 is one it loads
// - no buffer matches: signal a miss, hold back go, raise a microinterrupt
// - permission violation on a hit: no go, clear bit 16, microinterrupt
// - physical address is relocation value joined to address bits 10..0
// - with bit 28 clear write the invalid buffer, else alternate a and b
package vat_pkg;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_ENTRY = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_RDBACK = 4'hc;

  localparam logic [31:0] CTRL_RESET = 32'h0021_0400;

  localparam int unsigned CTL_TASK_LSB = 7;
  localparam int unsigned CTL_STOP = 10;
  localparam int unsigned CTL_ACCESS_EN = 16;
  localparam int unsigned CTL_XLATE_ON = 20;
  localparam int unsigned CTL_CNT_DONE = 21;
  localparam int unsigned CTL_BUF_SEL = 27;
  localparam int unsigned CTL_ADDR_SRC = 28;
  localparam int unsigned CTL_ISOLATE = 29;

  localparam int unsigned CNT_W = 10;
  localparam int unsigned LINE_W = 6;
  localparam int unsigned TASK_W = 3;
  localparam int unsigned IDX_W = 9;
  localparam int unsigned BUF_DEPTH = 512;

  localparam int unsigned ENT_TAG_LSB = 0;
  localparam int unsigned ENT_TAG_W = 7;
  localparam int unsigned ENT_VALID = 7;
  localparam int unsigned ENT_PERM_RD = 8;
  localparam int unsigned ENT_PERM_WR = 9;
  localparam int unsigned ENT_PERM_EX = 10;
  localparam int unsigned ENT_RELOC_LSB = 11;
  localparam int unsigned RELOC_W = 13;
  localparam int unsigned ENT_W = 24;
  localparam int unsigned PAR_W = 3;
  localparam int unsigned MEM_W = 27;
  localparam int unsigned OFFS_W = 11;

  localparam int unsigned STAT_MISS = 0;
  localparam int unsigned STAT_PROT = 1;
  localparam int unsigned STAT_BUSY = 2;
  localparam int unsigned STAT_ALT = 3;

  typedef enum logic [1:0] {
    VAT_IDLE = 2'h1,
    VAT_LOOK = 2'h2
  } vat_stage_t;

  // even parity per byte of the entry data
  function automatic logic [2:0] vat_parity(input logic [23:0] d);
    vat_parity = {^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction

  // buffer index: task area from control, line from address bits 19..17 and 13..11
  function automatic logic [8:0] vat_index(input logic [31:0] ctl, input logic [23:0] va);
    vat_index = {ctl[9:7], va[19:17], va[13:11]};
  endfunction

  // entry usable and tag equal to address bits 23..20 and 16..14, parity clean
  function automatic logic vat_match(input logic [26:0] w, input logic [23:0] va);
    vat_match = w[7] && (w[6:0] == {va[23:20], va[16:14]})
      && (w[26:24] == vat_parity(w[23:0]));
  endfunction

endpackage

/* File: rtl/vat_mem.sv */
// one translation buffer memory with registered read data
`timescale 1ns/1ps
module vat_mem #(
  parameter int unsigned WIDTH = 27,
  parameter int unsigned DEPTH = 512,
  parameter int unsigned AW = 9
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);

  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("vat_mem depth must equal two to the address width");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] rdata_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem_reg[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= mem_reg[i_raddr];
    end
  end

  assign o_rdata = rdata_reg;

endmodule

/* File: tb/vat_cpu_model.sv */
// processor side model that issues lookups to the translator
`timescale 1ns/1ps
module vat_cpu_model (
  input wire logic i_clk_sys,
  input wire logic i_ready,
  input wire logic i_done,
  output logic o_req,
  output logic [23:0] o_vaddr,
  output logic o_op_read,
  output logic o_op_write,
  output logic o_op_fetch,
  output logic o_timeout
);
  initial begin
    o_req = 1'b0;
    o_vaddr = 24'h00_0000;
    o_op_read = 1'b0;
    o_op_write = 1'b0;
    o_op_fetch = 1'b0;
    o_timeout = 1'b0;
  end

  // op 0 read, 1 write, 2 fetch; returns in the cycle the result stands
  task automatic lookup(input logic [23:0] va, input logic [1:0] op);
    int n;
    @(posedge i_clk_sys);
    o_req <= 1'b1;
    o_vaddr <= va;
    o_op_read <= (op == 2'd0);
    o_op_write <= (op == 2'd1);
    o_op_fetch <= (op == 2'd2);
    @(posedge i_clk_sys);
    o_req <= 1'b0;
    o_vaddr <= ~va;
    for (n = 0; n < 4; n++) begin
      @(posedge i_clk_sys);
      #1;
      if (i_done === 1'b1) begin
        return;
      end
    end
    o_timeout <= 1'b1;
  endtask
endmodule

/* File: tb/virtual_address_translation_buffer_tb.sv */
// self-checking bench for the virtual address translation buffer
`timescale 1ns/1ps
module virtual_address_translation_buffer_tb;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_reg_addr = 4'h0;
  logic [31:0] i_reg_wdata = 32'h0000_0000;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [31:0] o_reg_rdata;
  logic i_req, i_op_read, i_op_write, i_op_fetch, o_ready, o_done, o_hit_a, o_hit_b;
  logic o_miss, o_prot_err, o_go, o_micro_int, cpu_timeout;
  logic [23:0] i_vaddr, o_phys_addr;
  logic [31:0] seed = 32'h91e9_52a4;
  int mismatches = 0;
  int checks = 0;

  always #25 i_clk_sys = ~i_clk_sys;

  vat_translator u_dut (.i_clk_sys, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .i_req, .i_vaddr, .i_op_read, .i_op_write, .i_op_fetch,
    .o_ready, .o_done, .o_hit_a, .o_hit_b, .o_miss, .o_prot_err, .o_go, .o_micro_int,
    .o_phys_addr);

  vat_cpu_model u_cpu (.i_clk_sys, .i_ready(o_ready), .i_done(o_done), .o_req(i_req),
    .o_vaddr(i_vaddr), .o_op_read(i_op_read), .o_op_write(i_op_write),
    .o_op_fetch(i_op_fetch), .o_timeout(cpu_timeout));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge cpu_timeout) begin
    mismatches++;
    finish_test();
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // control word: latch addressing, translation on, access enabled, counter stopped
  function automatic logic [31:0] ctl(input logic [2:0] t, input logic b, input logic iso);
    return 32'h1031_0400 | {2'b00, iso, 1'b0, b, 27'h0} | {22'h0, t, 7'h00};
  endfunction

  function automatic logic [2:0] par(input logic [23:0] e);
    return {^e[23:16], ^e[15:8], ^e[7:0]};
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    #1;
    d = o_reg_rdata;
  endtask

  task automatic res(input logic ha, input logic hb, input logic ms, input logic pe,
      input logic [23:0] pa);
    chk("hit_a", ha, o_hit_a);
    chk("hit_b", hb, o_hit_b);
    chk("miss", ms, o_miss);
    chk("prot_err", pe, o_prot_err);
    chk("go", (ha | hb) & ~pe, o_go);
    chk("micro_int", ms | pe, o_micro_int);
    chk("ready", 1'b1, o_ready);
    if (o_go === 1'b1) chk("phys", pa, o_phys_addr);
  endtask

  // zero the word at this address in both buffers of task area t
  task automatic inval(input logic [2:0] t, input logic [23:0] va);
    wr(vat_pkg::ADDR_CTRL, ctl(t, 1'b0, 1'b0));
    u_cpu.lookup(va, 2'd0);
    wr(vat_pkg::ADDR_ENTRY, 32'h0000_0000);
    wr(vat_pkg::ADDR_CTRL, ctl(t, 1'b1, 1'b0));
    wr(vat_pkg::ADDR_ENTRY, 32'h0000_0000);
  endtask

  initial begin
    logic [31:0] r;
    logic [23:0] va, e;
    logic [2:0] t, pm;
    logic [1:0] op;
    logic b, viol;
    int i;
    repeat (10) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    rd(vat_pkg::ADDR_CTRL, r);
    chk("ctrl reset", vat_pkg::CTRL_RESET, r);
    rd(vat_pkg::ADDR_STATUS, r);
    chk("status reset", 32'h0000_0000, r);
    rd(4'h2, r);
    chk("unmapped read", 32'h0000_0000, r);
    r = rnd();
    u_cpu.lookup(r[23:0], 2'd1);
    res(1'b1, 1'b0, 1'b0, 1'b0, r[23:0]);
    for (i = 0; i < 12; i++) begin
      r = rnd();
      va = r[23:0];
      r = rnd();
      t = r[2:0];
      b = r[3];
      pm = (i < 3) ? 3'h7 : r[6:4];
      op = (r[8:7] == 2'd3) ? 2'd0 : r[8:7];
      e = {r[21:9], pm, 1'b1, va[23:20], va[16:14]};
      viol = ~pm[op];
      inval(t, va);
      wr(vat_pkg::ADDR_CTRL, ctl(t, b, 1'b0));
      wr(vat_pkg::ADDR_ENTRY, {8'h00, e});
      u_cpu.lookup(va, op);
      res(~b, b, 1'b0, viol, {e[23:11], va[10:0]});
      rd(vat_pkg::ADDR_RDBACK, r);
      chk("readback", {5'h00, par(e), e}, r);
      rd(vat_pkg::ADDR_CTRL, r);
      chk("access enable", {31'h0000_0000, ~viol}, r[16]);
      inval(t ^ 3'h1, va);
      wr(vat_pkg::ADDR_CTRL, ctl(t, b, 1'b0));
      u_cpu.lookup(va, op);
      res(~b, b, 1'b0, viol, {e[23:11], va[10:0]});
      u_cpu.lookup(va ^ 24'h10_0000, op);
      res(1'b0, 1'b0, 1'b1, 1'b0, 24'h00_0000);
      rd(vat_pkg::ADDR_STATUS, r);
      chk("miss flag", 1'b1, r[0]);
      wr(vat_pkg::ADDR_STATUS, 32'h0000_0003);
      rd(vat_pkg::ADDR_STATUS, r);
      chk("flags cleared", 2'b00, r[1:0]);
      wr(vat_pkg::ADDR_ENTRY, {8'h00, e & 24'hff_ff7f});
      u_cpu.lookup(va, op);
      res(1'b0, 1'b0, 1'b1, 1'b0, 24'h00_0000);
      wr(vat_pkg::ADDR_CTRL, ctl(t, b, 1'b1));
      wr(vat_pkg::ADDR_ENTRY, {8'h00, e});
      u_cpu.lookup(va, op);
      res(1'b0, 1'b0, 1'b1, 1'b0, 24'h00_0000);
      rd(vat_pkg::ADDR_RDBACK, r);
      chk("readback zero", 32'h0000_0000, r);
    end
    // start the counter: isolate on, counter addressing, task area 5
    wr(vat_pkg::ADDR_CTRL, 32'h2011_0280);
    for (i = 0; i < 60; i++) begin
      rd(vat_pkg::ADDR_CTRL, r);
      if (r[21] === 1'b1) break;
    end
    chk("counter done", 1'b1, r[21]);
    chk("task area", 3'h5, r[9:7]);
    chk("counter line", 6'h00, r[5:0]);
    finish_test();
  end
endmodule
